// ==== shared/icc_pkg.sv ====
// constants, types and opcodes of the instruction cycle control core
// Summary of operation
// - instruction cycle is four system clocks
// - plain instructions finish in one cycle
// - jump, invoke, exits, table read take two
// - write to program counter low jumps, two cycles
// - skip costs one extra cycle when taken
// - three transfer forms through the accumulator
// - add carries above 255, subtract borrows below zero
// - increment and decrement by one, selectable destination
// - logic operations set zero flag on zero
// - rotate one bit, plain forms wrap around
// - rotate via carry swaps end bit with carry
// - invoke saves next address, exit resumes there
// - unconditional jump saves no return address
// - skips test byte or bit, skip next
// - bit set and clear touch only one bit
// - table read fetches program memory data
// - power-down halts core; watchdog clear instruction
// - two-operand forms always take one operand via the accumulator
// - add and subtract update Z, C, AC, OV
// - plain rotates leave all flags unchanged
package icc_pkg;
  localparam int CLK_PER_INST = 4;
  localparam logic [1:0] LAST_PHASE = 2'(CLK_PER_INST - 1);
  localparam int PC_W = 10;
  localparam int DMEM_WORDS = 32;
  localparam int STACK_DEPTH = 4;
  localparam logic [4:0] PC_LOW_ADDR = 5'h02;
  localparam logic [1:0] TBL_PAGE = 2'h3;
  localparam logic [9:0] PC_RESET = 10'h000;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INFO = 8'h08;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_FLUSH = 2'b00,
    ST_EXEC = 2'b01,
    ST_TABLE = 2'b11,
    ST_HALT = 2'b10
  } icc_ctl_t;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_XFER_A_M = 6'h01, OP_XFER_M_A = 6'h02, OP_XFER_A_I = 6'h03,
    OP_ADD = 6'h04, OP_ADC = 6'h05, OP_SUB = 6'h06, OP_SBC = 6'h07,
    OP_ADD_I = 6'h08, OP_SUB_I = 6'h09, OP_AND = 6'h0A, OP_OR = 6'h0B,
    OP_XOR = 6'h0C, OP_AND_I = 6'h0D, OP_OR_I = 6'h0E, OP_XOR_I = 6'h0F,
    OP_COMPL = 6'h10, OP_INC = 6'h11, OP_MINUS_ONE = 6'h12, OP_ROT_R = 6'h13,
    OP_ROT_L = 6'h14, OP_ROT_RC = 6'h15, OP_ROT_LC = 6'h16, OP_SZ = 6'h17,
    OP_SZ_BIT = 6'h18, OP_SNZ_BIT = 6'h19, OP_SET_BIT = 6'h1A, OP_CLR_BIT = 6'h1B,
    OP_UJUMP = 6'h1C, OP_CALL = 6'h1D, OP_SUB_EXIT = 6'h1E, OP_INT_EXIT = 6'h1F,
    OP_TABRD = 6'h20, OP_HALT = 6'h21, OP_CLRWDT = 6'h22
  } icc_op_t;
endpackage : icc_pkg

// ==== hdl/icc_core.sv ====
// instruction cycle control core with its ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module icc_core
  import icc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [9:0] progAddr,
  input wire logic [15:0] progData,
  output logic wdtClear,
  output logic powerDown
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    icc_ctl_t ctl;
    logic [1:0] phase;
    logic [PC_W-1:0] pc;
    logic [15:0] ir;
    logic [7:0] acc;
    logic z;
    logic c;
    logic ac;
    logic ov;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [1:0] sp;
    logic [DMEM_WORDS-1:0][7:0] dmem;
    logic run;
    logic [15:0] instCount;
    logic [7:0] tblHigh;
    logic [4:0] tblDest;
    logic [PC_W-1:0] progAddr;
    logic wdtClear;
    logic halted;
    logic busSel;
    logic busWrite;
    logic [7:0] busAddr;
    logic [31:0] hrdata;
    logic hready;
  } icc_state_t;

  icc_state_t s_ff;
  icc_state_t nxt_s;

  logic cycleEnd;
  logic execEnd;
  icc_op_t op;
  logic [4:0] mAddr;
  logic [2:0] bitIdx;
  logic toMem;
  logic [7:0] imm;
  logic [7:0] mval;
  logic [7:0] res;
  logic [7:0] bx;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] sumLo;
  logic wrDst;
  logic wrAcc;
  logic jump;
  logic skip;
  logic [PC_W-1:0] jumpTgt;
  logic [PC_W-1:0] curAddr;
  logic [7:0] bitMask;
  logic addrOk;
  logic [31:0] rdMux;

  assign op = icc_op_t'(s_ff.ir[15:10]);
  assign mAddr = s_ff.ir[4:0];
  assign bitIdx = s_ff.ir[7:5];
  assign toMem = s_ff.ir[8];
  assign imm = s_ff.ir[7:0];
  assign curAddr = s_ff.pc - 10'h001;
  // the counter low byte reads as the executing instruction's address
  assign mval = (mAddr == PC_LOW_ADDR) ? curAddr[7:0] : s_ff.dmem[mAddr];
  assign bitMask = 8'h01 << bitIdx;
  assign cycleEnd = s_ff.run && (s_ff.ctl != ST_HALT) && (s_ff.phase == LAST_PHASE);
  assign execEnd = cycleEnd && (s_ff.ctl == ST_EXEC);

  // ****************************************
  // arithmetic operand path
  // ****************************************
  always_comb begin
    bx = 8'h00;
    cin = 1'b0;
    case (op)
      OP_ADD: bx = mval;
      OP_ADC: begin
        bx = mval;
        cin = s_ff.c;
      end
      OP_ADD_I: bx = imm;
      // carry set means no borrow, so carry clear flags a result below zero
      OP_SUB: begin
        bx = ~mval;
        cin = 1'b1;
      end
      OP_SBC: begin
        bx = ~mval;
        cin = s_ff.c;
      end
      OP_SUB_I: begin
        bx = ~imm;
        cin = 1'b1;
      end
      default: bx = 8'h00;
    endcase
    sum9 = {1'b0, s_ff.acc} + {1'b0, bx} + {8'h00, cin};
    sumLo = {1'b0, s_ff.acc[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
  end

  // ****************************************
  // register read mux
  // ****************************************
  assign addrOk = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);

  always_comb begin
    rdMux = RDATA_UNMAPPED;
    if (addrOk) begin
      case (haddr[7:0])
        REG_CTRL: rdMux = {31'h0, s_ff.run};
        REG_STATUS: begin
          rdMux = {6'h00, s_ff.pc, 1'b0, s_ff.ctl, s_ff.halted, s_ff.ov, s_ff.ac, s_ff.c, s_ff.z, s_ff.acc};
        end
        REG_INFO: rdMux = {s_ff.tblHigh, 8'h00, s_ff.instCount};
        default: rdMux = RDATA_UNMAPPED;
      endcase
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.wdtClear = 1'b0;
    res = 8'h00;
    wrDst = 1'b0;
    wrAcc = 1'b0;
    jump = 1'b0;
    skip = 1'b0;
    jumpTgt = s_ff.ir[9:0];
    if (s_ff.run && (s_ff.ctl != ST_HALT)) begin
      nxt_s.phase = s_ff.phase + 2'd1;
    end
    if (cycleEnd) begin
      case (s_ff.ctl)
        // extra cycle: prefetched word already dropped, refetch here
        ST_FLUSH: begin
          nxt_s.ir = progData;
          nxt_s.pc = s_ff.pc + 10'h001;
          nxt_s.ctl = ST_EXEC;
        end
        ST_TABLE: begin
          nxt_s.dmem[s_ff.tblDest] = progData[7:0];
          nxt_s.tblHigh = progData[15:8];
          nxt_s.ctl = ST_EXEC;
        end
        ST_EXEC: begin
          // overlapped fetch: next word enters while this one retires
          nxt_s.ir = progData;
          nxt_s.pc = s_ff.pc + 10'h001;
          nxt_s.instCount = s_ff.instCount + 16'h0001;
          case (op)
            OP_XFER_A_M: begin
              nxt_s.acc = mval;
            end
            OP_XFER_M_A: begin
              res = s_ff.acc;
              wrDst = 1'b1;
            end
            OP_XFER_A_I: begin
              nxt_s.acc = imm;
            end
            OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_ADD_I, OP_SUB_I: begin
              res = sum9[7:0];
              nxt_s.c = sum9[8];
              nxt_s.ac = sumLo[4];
              nxt_s.ov = (s_ff.acc[7] == bx[7]) && (sum9[7] != s_ff.acc[7]);
              nxt_s.z = (sum9[7:0] == 8'h00);
              wrDst = toMem && (op != OP_ADD_I) && (op != OP_SUB_I);
              wrAcc = !wrDst;
            end
            OP_AND, OP_OR, OP_XOR, OP_AND_I, OP_OR_I, OP_XOR_I, OP_COMPL: begin
              case (op)
                OP_AND: res = s_ff.acc & mval;
                OP_OR: res = s_ff.acc | mval;
                OP_XOR: res = s_ff.acc ^ mval;
                OP_AND_I: res = s_ff.acc & imm;
                OP_OR_I: res = s_ff.acc | imm;
                OP_XOR_I: res = s_ff.acc ^ imm;
                default: res = ~mval;
              endcase
              nxt_s.z = (res == 8'h00);
              wrDst = toMem && (op != OP_AND_I) && (op != OP_OR_I) && (op != OP_XOR_I);
              wrAcc = !wrDst;
            end
            OP_INC, OP_MINUS_ONE: begin
              res = (op == OP_INC) ? mval + 8'h01 : mval - 8'h01;
              nxt_s.z = (res == 8'h00);
              wrDst = toMem;
              wrAcc = !toMem;
            end
            OP_ROT_R, OP_ROT_L: begin
              // plain rotates never touch the flags
              res = (op == OP_ROT_R) ? {mval[0], mval[7:1]} : {mval[6:0], mval[7]};
              wrDst = toMem;
              wrAcc = !toMem;
            end
            OP_ROT_RC, OP_ROT_LC: begin
              res = (op == OP_ROT_RC) ? {s_ff.c, mval[7:1]} : {mval[6:0], s_ff.c};
              nxt_s.c = (op == OP_ROT_RC) ? mval[0] : mval[7];
              wrDst = toMem;
              wrAcc = !toMem;
            end
            OP_SZ: begin
              skip = (mval == 8'h00);
            end
            OP_SZ_BIT: begin
              skip = !mval[bitIdx];
            end
            OP_SNZ_BIT: begin
              skip = mval[bitIdx];
            end
            OP_SET_BIT, OP_CLR_BIT: begin
              // internal read-modify-write, other bits pass through
              res = (op == OP_SET_BIT) ? (mval | bitMask) : (mval & ~bitMask);
              wrDst = 1'b1;
            end
            OP_UJUMP: begin
              jump = 1'b1;
            end
            OP_CALL: begin
              nxt_s.stack[s_ff.sp] = s_ff.pc;
              nxt_s.sp = s_ff.sp + 2'd1;
              jump = 1'b1;
            end
            OP_SUB_EXIT, OP_INT_EXIT: begin
              // a fifth nested call overwrites the oldest return address
              jumpTgt = s_ff.stack[s_ff.sp - 2'd1];
              nxt_s.sp = s_ff.sp - 2'd1;
              jump = 1'b1;
            end
            OP_TABRD: begin
              nxt_s.ctl = ST_TABLE;
              nxt_s.tblDest = mAddr;
            end
            OP_HALT: begin
              nxt_s.ctl = ST_HALT;
            end
            OP_CLRWDT: begin
              nxt_s.wdtClear = 1'b1;
            end
            default: begin
              res = 8'h00;
            end
          endcase
          if (wrDst) begin
            if (mAddr == PC_LOW_ADDR) begin
              jumpTgt = {curAddr[9:8], res};
              jump = 1'b1;
            end else begin
              nxt_s.dmem[mAddr] = res;
            end
          end
          if (wrAcc) begin
            nxt_s.acc = res;
          end
          if (jump) begin
            nxt_s.pc = jumpTgt;
            nxt_s.ctl = ST_FLUSH;
          end else if (skip) begin
            nxt_s.ctl = ST_FLUSH;
          end
        end
        default: begin
          nxt_s.ctl = s_ff.ctl;
        end
      endcase
    end
    // table fetch borrows the program port for one instruction cycle
    nxt_s.progAddr = (nxt_s.ctl == ST_TABLE) ? {TBL_PAGE, nxt_s.acc} : nxt_s.pc;
    // bus: address phase sampled, write applied in data phase
    nxt_s.hready = 1'b1;
    if (s_ff.busSel && s_ff.busWrite && (s_ff.busAddr == REG_CTRL)) begin
      nxt_s.run = hwdata[CTRL_RUN_BIT];
      if (hwdata[CTRL_WAKE_BIT] && (s_ff.ctl == ST_HALT)) begin
        nxt_s.ctl = ST_EXEC;
        nxt_s.phase = 2'd0;
      end
    end
    nxt_s.busSel = hsel && htrans[1] && hready;
    nxt_s.busWrite = hwrite;
    nxt_s.busAddr = addrOk ? haddr[7:0] : 8'hFF;
    if (hsel && htrans[1] && hready && !hwrite) begin
      nxt_s.hrdata = rdMux;
    end
    nxt_s.halted = (nxt_s.ctl == ST_HALT);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '0;
      s_ff.ctl <= ST_FLUSH;
      s_ff.pc <= PC_RESET;
      s_ff.progAddr <= PC_RESET;
      s_ff.hready <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign hrdata = s_ff.hrdata;
  assign hreadyout = s_ff.hready;
  assign hresp = 1'b0 & s_ff.hready;
  assign progAddr = s_ff.progAddr;
  assign wdtClear = s_ff.wdtClear;
  assign powerDown = s_ff.halted;

  // ****************************************
  // assertions
  // ****************************************
  property p_cycle_four;
    @(posedge clock) disable iff (!reset_n) cycleEnd |=> !cycleEnd [*3];
  endproperty
  a_cycle_four: assert property (p_cycle_four) else $error("instruction cycle shorter than four clocks");

  property p_plain_one;
    @(posedge clock) disable iff (!reset_n)
      (execEnd && op == OP_XFER_A_I) |=> (s_ff.ctl == ST_EXEC) && (s_ff.acc == $past(imm));
  endproperty
  a_plain_one: assert property (p_plain_one) else $error("immediate transfer not single cycle");

  property p_jump_two;
    @(posedge clock) disable iff (!reset_n)
      (execEnd && op == OP_UJUMP) |=> (s_ff.ctl == ST_FLUSH) && (s_ff.pc == $past(s_ff.ir[9:0]))
        && (s_ff.sp == $past(s_ff.sp));
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("jump did not flush to target");

  property p_pcl_write;
    @(posedge clock) disable iff (!reset_n)
      (execEnd && op == OP_XFER_M_A && mAddr == PC_LOW_ADDR) |=> (s_ff.ctl == ST_FLUSH)
        && (s_ff.pc[7:0] == $past(s_ff.acc));
  endproperty
  a_pcl_write: assert property (p_pcl_write) else $error("counter low write did not jump");

  property p_skip;
    @(posedge clock) disable iff (!reset_n)
      (execEnd && op == OP_SZ) |=> (s_ff.ctl == ST_FLUSH) == ($past(mval) == 8'h00);
  endproperty
  a_skip: assert property (p_skip) else $error("skip cycle count wrong");

  property p_call_ret;
    @(posedge clock) disable iff (!reset_n)
      (execEnd && op == OP_CALL) |=> (s_ff.stack[s_ff.sp - 2'd1] == $past(s_ff.pc));
  endproperty
  a_call_ret: assert property (p_call_ret) else $error("invoke saved wrong return address");

  property p_rot_carry;
    @(posedge clock) disable iff (!reset_n)
      (execEnd && op == OP_ROT_RC) |=> (s_ff.c == $past(mval[0]));
  endproperty
  a_rot_carry: assert property (p_rot_carry) else $error("carry rotate lost end bit");

  property p_rot_flags;
    @(posedge clock) disable iff (!reset_n)
      (execEnd && (op == OP_ROT_R || op == OP_ROT_L)) |=> $stable({s_ff.z, s_ff.c, s_ff.ac, s_ff.ov});
  endproperty
  a_rot_flags: assert property (p_rot_flags) else $error("plain rotate changed flags");

  property p_logic_zero;
    @(posedge clock) disable iff (!reset_n)
      (execEnd && op == OP_AND_I) |=> (s_ff.z == (s_ff.acc == 8'h00));
  endproperty
  a_logic_zero: assert property (p_logic_zero) else $error("zero flag wrong after logic");

  property p_flush_fetch;
    @(posedge clock) disable iff (!reset_n)
      (cycleEnd && s_ff.ctl == ST_FLUSH) |=> (s_ff.ir == $past(progData)) && (s_ff.ctl == ST_EXEC);
  endproperty
  a_flush_fetch: assert property (p_flush_fetch) else $error("flush cycle did not refetch");

endmodule : icc_core
`default_nettype wire

// ==== dv/icc_prog_mem.sv ====
// program memory model serving instruction and table words to the core
`timescale 1ns/1ps
`default_nettype none
module icc_prog_mem (
  input wire logic clock,
  input wire logic [9:0] progAddr,
  output logic [15:0] progData
);
  // ****************
  // storage
  // ****************
  logic [15:0] mem [0:1023];
  logic [9:0] lastAddr;
  initial begin
    progData = 16'h0000;
    lastAddr = 10'h000;
  end
  // a fresh address shows garbage for one clock, never the previous word
  always @(posedge clock) begin
    if (progAddr !== lastAddr) begin
      progData <= ~progData;
      lastAddr <= progAddr;
    end else begin
      progData <= mem[progAddr];
    end
  end
endmodule : icc_prog_mem
`default_nettype wire

// ==== dv/tb_instruction_cycle_control.sv ====
// self-checking testbench of the instruction cycle control core
`timescale 1ns/1ps
`default_nettype none
module tb_instruction_cycle_control;
  import icc_pkg::*;
  // ****************
  // signals
  // ****************
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [9:0] progAddr;
  logic [15:0] progData;
  logic wdtClear;
  logic powerDown;
  logic [9:0] prevAddr = 10'h000;
  logic [9:0] traceAddr[$];
  int traceLen[$];
  int standLen = 0;
  int wdtPulses = 0;
  int cycles = 0;
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] rd;

  always #25 clock = ~clock;

  icc_core dut_u (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .progAddr(progAddr), .progData(progData), .wdtClear(wdtClear), .powerDown(powerDown));
  icc_prog_mem mem_u (.clock(clock), .progAddr(progAddr), .progData(progData));

  // ****************
  // monitors
  // ****************
  // fetch trace: each address with the number of clocks it stood
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (wdtClear === 1'h1) wdtPulses <= wdtPulses + 1;
    if (progAddr !== prevAddr) begin
      traceAddr.push_back(prevAddr);
      traceLen.push_back(standLen);
      standLen <= 1;
    end else begin
      standLen <= standLen + 1;
    end
    prevAddr <= progAddr;
    if (cycles == 20000) begin
      err_count++;
      $display("ERROR cycle_limit expected %0d seen %0d", 19999, cycles);
      report_and_stop();
    end
  end

  // ****************
  // tasks
  // ****************
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_val(input string what, input logic [31:0] expVal, input logic [31:0] gotVal);
    num_checks++;
    if (gotVal !== expVal) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, expVal, gotVal);
    end
  endtask : check_val

  // one single word transfer; read data lands in rd
  task automatic ahb_xfer(input logic [7:0] addr, input logic wr, input logic [31:0] wdata);
    @(posedge clock);
    hsel <= 1'h1;
    haddr <= {24'h000000, addr};
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'h2;
    @(posedge clock);
    while (hreadyout !== 1'h1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= wdata;
    @(posedge clock);
    while (hreadyout !== 1'h1) @(posedge clock);
    rd = hrdata;
    check_val("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask : ahb_xfer

  task automatic put(input int a, input icc_op_t op, input logic [9:0] f);
    mem_u.mem[a] = {op, f};
  endtask : put

  task automatic wait_pd(input logic lvl);
    while (powerDown !== lvl) @(posedge clock);
  endtask : wait_pd

  task automatic begin_scen();
    @(posedge clock);
    reset_n <= 1'h0;
    repeat (2) @(posedge clock);
    reset_n <= 1'h1;
    for (int i = 0; i < 1024; i++) mem_u.mem[i] = 16'h0000;
  endtask : begin_scen

  task automatic go();
    traceAddr.delete();
    traceLen.delete();
    wdtPulses = 0;
    ahb_xfer(REG_CTRL, 1'h1, 32'h0000_0001);
    wait_pd(1'h1);
  endtask : go

  // wake from power-down, run to the next halt
  task automatic resume();
    ahb_xfer(REG_CTRL, 1'h1, 32'h0000_0003);
    wait_pd(1'h0);
    wait_pd(1'h1);
  endtask : resume

  task automatic check_st(input logic [7:0] a, input logic z, input logic c);
    ahb_xfer(REG_STATUS, 1'h0, 32'h0000_0000);
    check_val("status_c_z_acc", {22'h0, c, z, a}, {22'h0, rd[9:0]});
    check_val("status_halted", 32'h0000_0001, {31'h0, rd[12]});
  endtask : check_st

  // ****************
  // scenarios
  // ****************
  task automatic scen_arith();
    begin_scen();
    ahb_xfer(REG_CTRL, 1'h0, 32'h0000_0000);
    check_val("ctrl_reset", 32'h0000_0000, rd);
    ahb_xfer(8'h0C, 1'h1, 32'hFFFF_FFFF);
    ahb_xfer(8'h0C, 1'h0, 32'h0000_0000);
    check_val("unmapped", RDATA_UNMAPPED, rd);
    put(0, OP_XFER_A_I, 10'h0F0);
    put(1, OP_XFER_M_A, 10'h005);
    put(2, OP_XFER_A_I, 10'h020);
    put(3, OP_ADD, 10'h005);
    put(4, OP_CLRWDT, 10'h000);
    put(5, OP_HALT, 10'h000);
    put(6, OP_SUB_I, 10'h011);
    put(7, OP_HALT, 10'h000);
    put(8, OP_ADC, 10'h005);
    put(9, OP_SBC, 10'h005);
    put(10, OP_SUB, 10'h105);
    put(11, OP_AND, 10'h005);
    put(12, OP_XOR, 10'h005);
    put(13, OP_HALT, 10'h000);
    go();
    check_st(8'h10, 1'h0, 1'h1);
    check_val("wdt_pulses", 32'h0000_0001, 32'(wdtPulses));
    resume();
    check_st(8'hFF, 1'h0, 1'h0);
    check_val("status_ov", 32'h0000_0000, {31'h0, rd[11]});
    resume();
    check_st(8'h00, 1'h1, 1'h1);
    check_val("status_ac", 32'h0000_0001, {31'h0, rd[10]});
  endtask : scen_arith

  task automatic scen_logic();
    begin_scen();
    put(0, OP_XFER_A_I, 10'h081);
    put(1, OP_XFER_M_A, 10'h007);
    put(2, OP_ADD_I, 10'h000);
    put(3, OP_AND_I, 10'h000);
    put(4, OP_ROT_L, 10'h007);
    put(5, OP_HALT, 10'h000);
    put(6, OP_OR_I, 10'h000);
    put(7, OP_ROT_LC, 10'h007);
    put(8, OP_ROT_RC, 10'h007);
    put(9, OP_HALT, 10'h000);
    put(10, OP_INC, 10'h107);
    put(11, OP_MINUS_ONE, 10'h007);
    put(12, OP_XOR_I, 10'h081);
    put(13, OP_HALT, 10'h000);
    put(14, OP_COMPL, 10'h107);
    put(15, OP_OR, 10'h007);
    put(16, OP_HALT, 10'h000);
    put(17, OP_ROT_R, 10'h107);
    put(18, OP_CLR_BIT, 10'h0E7);
    put(19, OP_SZ_BIT, 10'h007);
    put(20, OP_XFER_A_I, 10'h0FF);
    put(21, OP_ADD, 10'h007);
    put(22, OP_HALT, 10'h000);
    go();
    check_st(8'h03, 1'h1, 1'h0);
    resume();
    check_st(8'hC0, 1'h0, 1'h1);
    resume();
    check_st(8'h00, 1'h1, 1'h1);
    resume();
    check_st(8'h7D, 1'h0, 1'h1);
    resume();
    check_st(8'hBB, 1'h0, 1'h0);
  endtask : scen_logic

  task automatic scen_flow();
    logic [9:0] expTrace [18] = '{10'h000, 10'h001, 10'h004, 10'h005, 10'h010, 10'h011, 10'h005, 10'h006,
      10'h007, 10'h008, 10'h009, 10'h00A, 10'h00B, 10'h00C, 10'h014, 10'h015, 10'h016, 10'h314};
    begin_scen();
    put(0, OP_UJUMP, 10'h004);
    put(4, OP_CALL, 10'h010);
    put(16, OP_SUB_EXIT, 10'h000);
    put(5, OP_XFER_A_I, 10'h000);
    put(6, OP_XFER_M_A, 10'h009);
    put(7, OP_SZ, 10'h009);
    put(8, OP_XFER_A_I, 10'h055);
    put(9, OP_SNZ_BIT, 10'h009);
    put(10, OP_XFER_A_I, 10'h014);
    put(11, OP_XFER_M_A, 10'h002);
    put(20, OP_SET_BIT, 10'h069);
    put(21, OP_TABRD, 10'h00A);
    put(22, OP_XFER_A_M, 10'h00A);
    put(23, OP_OR, 10'h009);
    put(24, OP_HALT, 10'h000);
    mem_u.mem[10'h314] = 16'hA552;
    go();
    check_val("trace_depth", 32'h0000_0001, {31'h0, traceAddr.size() >= 18});
    for (int i = 0; i < 18 && i < traceAddr.size(); i++) begin
      check_val("fetch_addr", {22'h0, expTrace[i]}, {22'h0, traceAddr[i]});
      if (i > 0 && i < 17) check_val("fetch_stand", 32'h0000_0004, 32'(traceLen[i]));
    end
    ahb_xfer(REG_STATUS, 1'h0, 32'h0000_0000);
    check_val("acc_table_bit", 32'h0000_005A, {24'h0, rd[7:0]});
    check_val("status_pc", 32'h0000_001A, {22'h0, rd[25:16]});
    check_val("status_state", 32'h0000_0002, {30'h0, rd[14:13]});
    ahb_xfer(REG_INFO, 1'h0, 32'h0000_0000);
    check_val("table_high", 32'h0000_00A5, {24'h0, rd[31:24]});
  endtask : scen_flow

  initial begin
    scen_arith();
    scen_logic();
    scen_flow();
    report_and_stop();
  end
endmodule : tb_instruction_cycle_control
`default_nettype wire
